// [design/dfo_pkg.sv]
// Purpose: shared constants and types for the playback filter and output control
// Assumes: 8-bit register index, 16-bit register data
// Notes:   path index order is hp left, hp right, line left, line right
package dfo_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int NPATH  = 4;

   // register offsets
   localparam logic [ADDR_W-1:0] ADDR_HP_PWR  = 8'h0e;
   localparam logic [ADDR_W-1:0] ADDR_LN_PWR  = 8'h0f;
   localparam logic [ADDR_W-1:0] ADDR_FILT    = 8'h21;
   localparam logic [ADDR_W-1:0] ADDR_SRC     = 8'h3d;
   localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h3e;
   localparam logic [ADDR_W-1:0] ADDR_HP_STG  = 8'h5a;
   localparam logic [ADDR_W-1:0] ADDR_LN_STG  = 8'h5e;

   // field positions
   localparam int PWR_LEFT_BIT  = 1;
   localparam int PWR_RIGHT_BIT = 0;
   localparam int DEEMPHASIS_SELECT_LSB    = 1;
   localparam int OSR_BIT       = 6;
   localparam int SB_BIT        = 11;
   localparam int STG_L_LSB     = 4;
   localparam int STG_R_LSB     = 0;
   localparam int NIB_INP       = 0;
   localparam int NIB_MID       = 1;
   localparam int NIB_OUTP      = 2;
   localparam int NIB_UNGND     = 3;
   localparam int SRC_W         = 2;
   localparam int STAT_ACT_LSB  = 0;
   localparam int STAT_GND_LSB  = 4;

   // reset values
   localparam logic [1:0] RST_PWR    = 2'h0;
   localparam logic [1:0] RST_DEEMPHASIS_SELECT = 2'h0;
   localparam logic       RST_SB     = 1'b0;
   localparam logic       RST_OSR    = 1'b0;
   localparam logic [7:0] RST_STG    = 8'h00;
   localparam logic [7:0] RST_SRC    = 8'h00;

   // host-side settle time from input stage to middle stage
   localparam int CLK_PERIOD_NS = 50;
   localparam int T_IN_TO_MID_NS = 20000;
   localparam int CYC_IN_TO_MID =
      (T_IN_TO_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      DEEMPHASIS_SELECT_OFF,
      DEEMPHASIS_SELECT_32K,
      DEEMPHASIS_SELECT_44K1,
      DEEMPHASIS_SELECT_48K
   } dfo_deemphasis_select_t;

   typedef enum logic [SRC_W-1:0] {
      SRC_DAC,
      SRC_BYP_LEFT,
      SRC_BYP_RIGHT,
      SRC_DAC_ALT
   } dfo_src_t;

endpackage

// [design/dfo_out_path.sv]
// Purpose: per-output stage drive, ground short and source select
// Assumes: inputs come straight from control registers
// Notes:   outputs lag the register write by one clock
`timescale 1ns/1ps
module dfo_out_path (
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_amp_en,
   input  wire logic [3:0] i_stage,
   input  wire logic [1:0] i_src,
   output logic            o_amp_enable,
   output logic            o_input_stage_on,
   output logic            o_middle_stage_on,
   output logic            o_output_stage_on,
   output logic            o_short_to_ground,
   output logic            o_src_dac,
   output logic            o_src_left_bypass,
   output logic            o_src_right_bypass,
   output logic            o_active
);

   typedef struct packed {
      logic amp;
      logic inp;
      logic mid;
      logic outp;
      logic gnd;
      logic dac;
      logic bypl;
      logic bypr;
      logic act;
   } dfo_path_t;

   localparam dfo_path_t PATH_RST = '{
      amp: 1'b0, inp: 1'b0, mid: 1'b0, outp: 1'b0, gnd: 1'b1,
      dac: 1'b1, bypl: 1'b0, bypr: 1'b0, act: 1'b0};

   dfo_path_t s_q;
   dfo_path_t s_d;

   always_comb begin
      s_d      = s_q;
      s_d.amp  = i_amp_en;
      s_d.inp  = i_stage[dfo_pkg::NIB_INP];
      s_d.mid  = i_stage[dfo_pkg::NIB_MID];
      s_d.outp = i_stage[dfo_pkg::NIB_OUTP];
      // short stays until its own unground bit is set
      s_d.gnd  = ~i_stage[dfo_pkg::NIB_UNGND];
      s_d.dac  = 1'b0;
      s_d.bypl = 1'b0;
      s_d.bypr = 1'b0;
      case (dfo_pkg::dfo_src_t'(i_src))
         dfo_pkg::SRC_BYP_LEFT:  s_d.bypl = 1'b1;
         dfo_pkg::SRC_BYP_RIGHT: s_d.bypr = 1'b1;
         default:                s_d.dac  = 1'b1;
      endcase
      s_d.act  = i_amp_en & (&i_stage);
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s_q <= PATH_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_amp_enable       = s_q.amp;
   assign o_input_stage_on   = s_q.inp;
   assign o_middle_stage_on  = s_q.mid;
   assign o_output_stage_on  = s_q.outp;
   assign o_short_to_ground  = s_q.gnd;
   assign o_src_dac          = s_q.dac;
   assign o_src_left_bypass  = s_q.bypl;
   assign o_src_right_bypass = s_q.bypr;
   assign o_active           = s_q.act;

endmodule

// [design/dfo_ctrl.sv]
// Purpose: playback filter settings and output driver enable control
// Assumes: single 20 MHz clock, plain register port, host keeps sequencing
// Notes:   register data applies at the clock edge of the write
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module dfo_ctrl (
   input  wire logic                       i_clk,
   input  wire logic                       i_rst_b,
   input  wire logic [dfo_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [dfo_pkg::DATA_W-1:0] i_wdata,
   input  wire logic                       i_wr,
   input  wire logic                       i_rd,
   output logic [dfo_pkg::DATA_W-1:0]      o_rdata,
   output logic                            o_deemphasis_select_32k,
   output logic                            o_deemphasis_select_44k1,
   output logic                            o_deemphasis_select_48k,
   output logic                            o_sloping_stopband_select,
   output logic                            o_double_oversample_select,
   output logic [dfo_pkg::NPATH-1:0]       o_amp_enable,
   output logic [dfo_pkg::NPATH-1:0]       o_input_stage_on,
   output logic [dfo_pkg::NPATH-1:0]       o_middle_stage_on,
   output logic [dfo_pkg::NPATH-1:0]       o_output_stage_on,
   output logic [dfo_pkg::NPATH-1:0]       o_short_to_ground,
   output logic [dfo_pkg::NPATH-1:0]       o_src_dac,
   output logic [dfo_pkg::NPATH-1:0]       o_src_left_bypass,
   output logic [dfo_pkg::NPATH-1:0]       o_src_right_bypass
);

   typedef struct packed {
      logic [1:0]                hp_pwr;
      logic [1:0]                ln_pwr;
      logic [1:0]                deemphasis_select;
      logic                      sb;
      logic                      osr;
      logic [7:0]                hp_stg;
      logic [7:0]                ln_stg;
      logic [7:0]                src;
      logic                      dm32;
      logic                      dm44;
      logic                      dm48;
      logic [dfo_pkg::DATA_W-1:0] rdata;
   } dfo_ctrl_t;

   localparam dfo_ctrl_t CTRL_RST = '{
      hp_pwr: dfo_pkg::RST_PWR,
      ln_pwr: dfo_pkg::RST_PWR,
      deemphasis_select: dfo_pkg::RST_DEEMPHASIS_SELECT,
      sb:     dfo_pkg::RST_SB,
      osr:    dfo_pkg::RST_OSR,
      hp_stg: dfo_pkg::RST_STG,
      ln_stg: dfo_pkg::RST_STG,
      src:    dfo_pkg::RST_SRC,
      dm32:   1'b0,
      dm44:   1'b0,
      dm48:   1'b0,
      rdata:  16'h0000};

   dfo_ctrl_t s_q;
   dfo_ctrl_t s_d;

   logic [dfo_pkg::NPATH-1:0] path_act;

   // register writes and read data
   always_comb begin
      s_d       = s_q;
      s_d.rdata = 16'h0000;

      if (i_wr) begin
         if (i_addr == dfo_pkg::ADDR_HP_PWR) begin
            s_d.hp_pwr[1] = i_wdata[dfo_pkg::PWR_LEFT_BIT];
            s_d.hp_pwr[0] = i_wdata[dfo_pkg::PWR_RIGHT_BIT];
         end else if (i_addr == dfo_pkg::ADDR_LN_PWR) begin
            s_d.ln_pwr[1] = i_wdata[dfo_pkg::PWR_LEFT_BIT];
            s_d.ln_pwr[0] = i_wdata[dfo_pkg::PWR_RIGHT_BIT];
         end else if (i_addr == dfo_pkg::ADDR_FILT) begin
            s_d.deemphasis_select = i_wdata[dfo_pkg::DEEMPHASIS_SELECT_LSB +: 2];
            s_d.sb     = i_wdata[dfo_pkg::SB_BIT];
            s_d.osr    = i_wdata[dfo_pkg::OSR_BIT];
         end else if (i_addr == dfo_pkg::ADDR_SRC) begin
            s_d.src = i_wdata[7:0];
         end else if (i_addr == dfo_pkg::ADDR_HP_STG) begin
            s_d.hp_stg = i_wdata[7:0];
         end else if (i_addr == dfo_pkg::ADDR_LN_STG) begin
            s_d.ln_stg = i_wdata[7:0];
         end
      end

      // one curve per supported rate, none for any other
      s_d.dm32 = 1'b0;
      s_d.dm44 = 1'b0;
      s_d.dm48 = 1'b0;
      case (dfo_pkg::dfo_deemphasis_select_t'(s_d.deemphasis_select))
         dfo_pkg::DEEMPHASIS_SELECT_32K:  s_d.dm32 = 1'b1;
         dfo_pkg::DEEMPHASIS_SELECT_44K1: s_d.dm44 = 1'b1;
         dfo_pkg::DEEMPHASIS_SELECT_48K:  s_d.dm48 = 1'b1;
         default: ;
      endcase

      // reads see the state before a same-cycle write
      if (i_rd) begin
         if (i_addr == dfo_pkg::ADDR_HP_PWR) begin
            s_d.rdata[dfo_pkg::PWR_LEFT_BIT]  = s_q.hp_pwr[1];
            s_d.rdata[dfo_pkg::PWR_RIGHT_BIT] = s_q.hp_pwr[0];
         end else if (i_addr == dfo_pkg::ADDR_LN_PWR) begin
            s_d.rdata[dfo_pkg::PWR_LEFT_BIT]  = s_q.ln_pwr[1];
            s_d.rdata[dfo_pkg::PWR_RIGHT_BIT] = s_q.ln_pwr[0];
         end else if (i_addr == dfo_pkg::ADDR_FILT) begin
            s_d.rdata[dfo_pkg::DEEMPHASIS_SELECT_LSB +: 2] = s_q.deemphasis_select;
            s_d.rdata[dfo_pkg::SB_BIT]          = s_q.sb;
            s_d.rdata[dfo_pkg::OSR_BIT]         = s_q.osr;
         end else if (i_addr == dfo_pkg::ADDR_SRC) begin
            s_d.rdata[7:0] = s_q.src;
         end else if (i_addr == dfo_pkg::ADDR_STATUS) begin
            s_d.rdata[dfo_pkg::STAT_ACT_LSB +: 4] = path_act;
            s_d.rdata[dfo_pkg::STAT_GND_LSB +: 4] = o_short_to_ground;
         end else if (i_addr == dfo_pkg::ADDR_HP_STG) begin
            s_d.rdata[7:0] = s_q.hp_stg;
         end else if (i_addr == dfo_pkg::ADDR_LN_STG) begin
            s_d.rdata[7:0] = s_q.ln_stg;
         end
      end
   end

   // register fields land on the write edge; path outputs are staged one edge later
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s_q <= CTRL_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rdata                    = s_q.rdata;
   assign o_deemphasis_select_32k               = s_q.dm32;
   assign o_deemphasis_select_44k1              = s_q.dm44;
   assign o_deemphasis_select_48k               = s_q.dm48;
   assign o_sloping_stopband_select  = s_q.sb;
   assign o_double_oversample_select = s_q.osr;

   // one path block per output; no cross terms between paths
   for (genvar p = 0; p < dfo_pkg::NPATH; p++) begin : g_path
      localparam bit IS_HP   = (p < 2);
      localparam bit IS_LEFT = ((p % 2) == 0);

      logic [7:0] stg;
      logic [1:0] pwr;
      logic [3:0] nib;
      logic       amp;

      assign stg = IS_HP ? s_q.hp_stg : s_q.ln_stg;
      assign pwr = IS_HP ? s_q.hp_pwr : s_q.ln_pwr;
      assign nib = IS_LEFT ? stg[dfo_pkg::STG_L_LSB +: 4]
                           : stg[dfo_pkg::STG_R_LSB +: 4];
      assign amp = IS_LEFT ? pwr[1] : pwr[0];

      dfo_out_path u_path (
         .i_clk              (i_clk),
         .i_rst_b            (i_rst_b),
         .i_amp_en           (amp),
         .i_stage            (nib),
         .i_src              (s_q.src[p*dfo_pkg::SRC_W +: dfo_pkg::SRC_W]),
         .o_amp_enable       (o_amp_enable[p]),
         .o_input_stage_on   (o_input_stage_on[p]),
         .o_middle_stage_on  (o_middle_stage_on[p]),
         .o_output_stage_on  (o_output_stage_on[p]),
         .o_short_to_ground  (o_short_to_ground[p]),
         .o_src_dac          (o_src_dac[p]),
         .o_src_left_bypass  (o_src_left_bypass[p]),
         .o_src_right_bypass (o_src_right_bypass[p]),
         .o_active           (path_act[p])
      );
   end

endmodule

// [test/dfo_ctrl_assertions.sv]
// Purpose: concurrent checks on the playback control ports
// Assumes: one clock, asynchronous active-low reset
// Notes:   path outputs lag a register write by one edge
`timescale 1ns/1ps
module dfo_ctrl_assertions (
   input wire logic                       i_clk,
   input wire logic                       i_rst_b,
   input wire logic [dfo_pkg::ADDR_W-1:0] i_addr,
   input wire logic [dfo_pkg::DATA_W-1:0] i_wdata,
   input wire logic                       i_wr,
   input wire logic                       o_deemphasis_select_32k,
   input wire logic                       o_deemphasis_select_44k1,
   input wire logic                       o_deemphasis_select_48k,
   input wire logic                       o_sloping_stopband_select,
   input wire logic                       o_double_oversample_select,
   input wire logic [dfo_pkg::NPATH-1:0]  o_amp_enable,
   input wire logic [dfo_pkg::NPATH-1:0]  o_input_stage_on,
   input wire logic [dfo_pkg::NPATH-1:0]  o_output_stage_on,
   input wire logic [dfo_pkg::NPATH-1:0]  o_short_to_ground,
   input wire logic [dfo_pkg::NPATH-1:0]  o_src_dac,
   input wire logic [dfo_pkg::NPATH-1:0]  o_src_left_bypass,
   input wire logic [dfo_pkg::NPATH-1:0]  o_src_right_bypass
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);
   wire wf  = i_wr && i_addr == dfo_pkg::ADDR_FILT;
   wire whp = i_wr && i_addr == dfo_pkg::ADDR_HP_PWR;
   wire wln = i_wr && i_addr == dfo_pkg::ADDR_LN_PWR;
   wire wst = i_wr && i_addr == dfo_pkg::ADDR_HP_STG;
   wire [3:0] s_ovl = (o_src_dac & o_src_left_bypass) | (o_src_dac & o_src_right_bypass)
                    | (o_src_left_bypass & o_src_right_bypass);
   property p_deemphasis_select;
      wf |=> o_deemphasis_select_32k == ($past(i_wdata[2:1]) == 2'h1) && o_deemphasis_select_44k1 == ($past(i_wdata[2:1]) == 2'h2)
             && o_deemphasis_select_48k == ($past(i_wdata[2:1]) == 2'h3);
   endproperty
   property p_filt_bits;
      wf |=> o_sloping_stopband_select == $past(i_wdata[11]) && o_double_oversample_select == $past(i_wdata[6]);
   endproperty
   // no write, no change: stale settings must not drift
   property p_filt_hold;
      !wf |=> $stable(o_sloping_stopband_select) && $stable(o_double_oversample_select)
              && $stable({o_deemphasis_select_32k, o_deemphasis_select_44k1, o_deemphasis_select_48k});
   endproperty
   property p_hp_amp;
      whp ##1 !whp |=> o_amp_enable[1:0] == {$past(i_wdata[0], 2), $past(i_wdata[1], 2)};
   endproperty
   property p_ln_amp;
      wln ##1 !wln |=> o_amp_enable[3:2] == {$past(i_wdata[0], 2), $past(i_wdata[1], 2)};
   endproperty
   property p_short;
      wst ##1 !wst |=> o_short_to_ground[1:0] == ~{$past(i_wdata[3], 2), $past(i_wdata[7], 2)};
   endproperty
   property p_stage;
      wst ##1 !wst |=> o_input_stage_on[0] == $past(i_wdata[4], 2) && o_output_stage_on[1] == $past(i_wdata[2], 2);
   endproperty
   property p_src;
      s_ovl == 4'h0 && (o_src_dac | o_src_left_bypass | o_src_right_bypass) == 4'hf;
   endproperty
   a_deemphasis_select: assert property (p_deemphasis_select) else $error("deemphasis outputs differ from write");
   a_filt_bits: assert property (p_filt_bits) else $error("filter bits differ from write");
   a_filt_hold: assert property (p_filt_hold) else $error("filter setting moved without write");
   a_hp_amp: assert property (p_hp_amp) else $error("headphone amp enable wrong");
   a_ln_amp: assert property (p_ln_amp) else $error("line amp enable wrong");
   a_short: assert property (p_short) else $error("ground short wrong");
   a_stage: assert property (p_stage) else $error("stage bit placement wrong");
   a_src: assert property (p_src) else $error("source select not one-hot");
   c_deemphasis_select_48k: cover property (wf ##1 o_deemphasis_select_48k);
   c_hp_write: cover property (whp);
   c_unground: cover property (o_short_to_ground != 4'hf);
endmodule

bind dfo_ctrl dfo_ctrl_assertions u_dfo_ctrl_assertions (.i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .o_deemphasis_select_32k,
   .o_deemphasis_select_44k1, .o_deemphasis_select_48k, .o_sloping_stopband_select, .o_double_oversample_select, .o_amp_enable,
   .o_input_stage_on, .o_output_stage_on, .o_short_to_ground, .o_src_dac, .o_src_left_bypass, .o_src_right_bypass);

// [test/dfo_ctrl_tb.sv]
// Purpose: directed bench for playback filter and output control
// Assumes: host keeps the enable order; reference and bias count as up; no sequencer model
// Notes:   path outputs are checked one edge after each write
`timescale 1ns/1ps
module dfo_ctrl_tb;
   logic        i_clk, i_rst_b, i_wr, i_rd;
   logic [7:0]  i_addr;
   logic [15:0] i_wdata, o_rdata;
   logic        o_deemphasis_select_32k, o_deemphasis_select_44k1, o_deemphasis_select_48k, o_sloping_stopband_select, o_double_oversample_select;
   logic [3:0]  o_amp_enable, o_input_stage_on, o_middle_stage_on, o_output_stage_on, o_short_to_ground;
   logic [3:0]  o_src_dac, o_src_left_bypass, o_src_right_bypass;
   int          error_cnt, checks;
   logic [15:0] st_exp [4] = '{16'h100f, 16'h110f, 16'h111f, 16'h111e};
   logic [7:0]  st_val [4] = '{8'h10, 8'h30, 8'h70, 8'hf0};

   dfo_ctrl u_dfo_ctrl (.i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_deemphasis_select_32k, .o_deemphasis_select_44k1,
      .o_deemphasis_select_48k, .o_sloping_stopband_select, .o_double_oversample_select, .o_amp_enable, .o_input_stage_on,
      .o_middle_stage_on, .o_output_stage_on, .o_short_to_ground, .o_src_dac, .o_src_left_bypass, .o_src_right_bypass);

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge i_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, e);
   endtask
   // one more edge lets the per-path registers follow the write
   task automatic settle;
      @(posedge i_clk);
      #1;
   endtask
   task automatic t_reset;
      rd(dfo_pkg::ADDR_HP_PWR, 16'h0000);
      rd(dfo_pkg::ADDR_LN_PWR, 16'h0000);
      rd(dfo_pkg::ADDR_FILT, 16'h0000);
      rd(dfo_pkg::ADDR_HP_STG, 16'h0000);
      rd(dfo_pkg::ADDR_STATUS, 16'h00f0);
      chk({o_deemphasis_select_48k, o_deemphasis_select_44k1, o_deemphasis_select_32k, o_sloping_stopband_select}, 16'h0000);
      chk(o_double_oversample_select, 16'h0000);
      chk({o_short_to_ground, o_src_dac, o_amp_enable}, 16'h0ff0);
   endtask
   task automatic t_filter;
      logic [15:0] d;
      for (int i = 0; i < 4; i++) begin
         d = (16'(i) << 1) | (i[0] ? 16'h0800 : 16'h0040);
         wr(dfo_pkg::ADDR_FILT, d);
         chk({o_deemphasis_select_48k, o_deemphasis_select_44k1, o_deemphasis_select_32k}, (16'h0001 << i) >> 1);
         chk({o_sloping_stopband_select, o_double_oversample_select}, {i[0], !i[0]});
         rd(dfo_pkg::ADDR_FILT, d);
      end
      wr(dfo_pkg::ADDR_FILT, 16'hffff);
      rd(dfo_pkg::ADDR_FILT, 16'h0846);
   endtask
   task automatic t_paths;
      wr(dfo_pkg::ADDR_HP_PWR, 16'h0002);
      settle;
      chk(o_amp_enable, 16'h0001);
      for (int i = 0; i < 4; i++) begin
         wr(dfo_pkg::ADDR_HP_STG, {8'h00, st_val[i]});
         settle;
         chk({o_input_stage_on, o_middle_stage_on, o_output_stage_on, o_short_to_ground}, st_exp[i]);
         // input stage needs its settle time before the middle stage
         if (i == 0) repeat (dfo_pkg::CYC_IN_TO_MID) @(posedge i_clk);
         // offset correction slot between middle and output stage
         if (i == 1) settle;
      end
      wr(dfo_pkg::ADDR_LN_PWR, 16'h0001);
      wr(dfo_pkg::ADDR_LN_STG, 16'h0001);
      repeat (dfo_pkg::CYC_IN_TO_MID) @(posedge i_clk);
      wr(dfo_pkg::ADDR_LN_STG, 16'h0003);
      settle;
      wr(dfo_pkg::ADDR_LN_STG, 16'h0007);
      wr(dfo_pkg::ADDR_LN_STG, 16'h000f);
      settle;
      chk(o_amp_enable, 16'h0009);
      rd(dfo_pkg::ADDR_STATUS, 16'h0069);
      wr(dfo_pkg::ADDR_STATUS, 16'hffff);
      rd(dfo_pkg::ADDR_STATUS, 16'h0069);
      wr(dfo_pkg::ADDR_HP_STG, 16'h0070);
      settle;
      chk({o_input_stage_on, o_middle_stage_on, o_output_stage_on, o_short_to_ground}, 16'h9997);
      wr(dfo_pkg::ADDR_HP_STG, 16'h0000);
      settle;
      chk({o_input_stage_on, o_middle_stage_on, o_output_stage_on, o_short_to_ground}, 16'h8887);
   endtask
   task automatic t_src;
      wr(dfo_pkg::ADDR_SRC, 16'h0039);
      settle;
      chk({o_src_dac, o_src_left_bypass, o_src_right_bypass}, 16'h0c12);
      rd(dfo_pkg::ADDR_SRC, 16'h0039);
      wr(8'h40, 16'hffff);
      rd(8'h40, 16'h0000);
   endtask
   task automatic complete_run;
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   // whole run is about a thousand cycles; four thousand leaves ample margin
   initial begin
      #200000;
      error_cnt++;
      complete_run;
   end
   initial begin
      {i_rst_b, i_wr, i_rd, i_addr, i_wdata} = '0;
      repeat (8) @(posedge i_clk);
      i_rst_b <= 1'b1;
      t_reset;
      t_filter;
      t_paths;
      t_src;
      complete_run;
   end
endmodule
